// >>> erw_record_window.sv
/*
 * Selected error record window: a small bank of error records reached
 * through coprocessor read and write requests, with a selector, a count,
 * privilege checks and trap routing to the hypervisor and monitor levels.
 * Assumes one request per cycle at most, held for one cycle only, and that
 * the core raises the exception named by the answer on its own.
 */
`timescale 1ns/1ps

module erw_record_window (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [3:0] reqCoproc,
  input wire logic [2:0] reqOpc1,
  input wire logic [3:0] reqCrn,
  input wire logic [3:0] reqCrm,
  input wire logic [2:0] reqOpc2,
  input wire logic [31:0] reqWdata,
  input wire logic [1:0] curLevel,
  input wire logic curSecure,
  input wire logic rasPresent,
  input wire logic hypPresent,
  input wire logic hypWide,
  input wire logic hypWideTrap,
  input wire logic hypNarrowTrap,
  input wire logic monPresent,
  input wire logic monWide,
  input wire logic monWideTrap,
  input wire logic monNarrowTrap,
  output logic respValid,
  output logic [31:0] respRdata,
  output logic respUndef,
  output logic respHypTrap,
  output logic respMonTrap
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // True for any encoding this block answers
  function automatic logic isMine(input logic [3:0] cp,
                                  input logic [2:0] o1,
                                  input logic [3:0] crn,
                                  input logic [3:0] crm,
                                  input logic [2:0] o2);
    logic base;
    logic ident;
    logic view;
    base = (cp == erw_pkg::CP_NUM) && (o1 == erw_pkg::CP_OPC1) &&
           (crn == erw_pkg::CP_CRN);
    ident = (crm == erw_pkg::CRM_IDENT) &&
            ((o2 == erw_pkg::OP2_COUNT) || (o2 == erw_pkg::OP2_SELECT));
    view = (crm == erw_pkg::CRM_VIEW) &&
           ((o2 == erw_pkg::OP2_FEAT_LO) || (o2 == erw_pkg::OP2_CTL_LO) ||
            (o2 == erw_pkg::OP2_ADDR_LO) || (o2 == erw_pkg::OP2_CTL_HI) ||
            (o2 == erw_pkg::OP2_ADDR_HI));
    return base && (ident || view);
  endfunction : isMine

  // True for encodings that only accept reads
  function automatic logic isReadOnly(input logic [3:0] crm,
                                      input logic [2:0] o2);
    return ((crm == erw_pkg::CRM_VIEW) && (o2 == erw_pkg::OP2_FEAT_LO)) ||
           ((crm == erw_pkg::CRM_IDENT) && (o2 == erw_pkg::OP2_COUNT));
  endfunction : isReadOnly

  // Merge one 32-bit half into a 64-bit word
  function automatic logic [63:0] putHalf(input logic [63:0] word,
                                          input logic hi,
                                          input logic [31:0] data);
    logic [63:0] res;
    res = word;
    if (hi) begin
      res[63:32] = data;
    end else begin
      res[31:0] = data;
    end
    return res;
  endfunction : putHalf

  // Pick one 32-bit half of a 64-bit word
  function automatic logic [31:0] getHalf(input logic [63:0] word,
                                          input logic hi);
    return hi ? word[63:32] : word[31:0];
  endfunction : getHalf

  ////////////////////////////////////////////////////////////////////////
  // State

  // One copy per record, not banked by security state
  logic [15:0] selector_r;
  logic [15:0] selector_nxt;
  logic [63:0] addrRec_r [erw_pkg::RECORDS];
  logic [63:0] addrRec_nxt [erw_pkg::RECORDS];
  logic [63:0] ctlRec_r [erw_pkg::RECORDS];
  logic [63:0] ctlRec_nxt [erw_pkg::RECORDS];

  logic respValid_r;
  logic respValid_nxt;
  logic [31:0] respRdata_r;
  logic [31:0] respRdata_nxt;
  logic respUndef_r;
  logic respUndef_nxt;
  logic respHypTrap_r;
  logic respHypTrap_nxt;
  logic respMonTrap_r;
  logic respMonTrap_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Access checks

  logic hit;
  logic undef;
  logic nsKernel;
  logic hypTrap;
  logic monTrap;
  logic inRange;
  logic [erw_pkg::IDX_W-1:0] idx;
  logic doAccess;
  logic isView;
  logic selWrite;
  logic selRead;
  logic viewWrite;
  logic viewRead;

  assign hit = reqValid && isMine(reqCoproc, reqOpc1, reqCrn, reqCrm,
                                  reqOpc2);
  assign isView = (reqCrm == erw_pkg::CRM_VIEW);

  // Missing extension, user level, or a write to a read-only word
  assign undef = !rasPresent ||
                 (curLevel == erw_pkg::LVL_USER) ||
                 (reqWrite && isReadOnly(reqCrm, reqOpc2));

  assign nsKernel = (curLevel == erw_pkg::LVL_KERNEL) && !curSecure;

  // Hypervisor traps are checked before monitor traps: a trap to the
  // lower target level wins when both would apply.
  assign hypTrap = hypPresent && nsKernel &&
                   ((hypWide && hypWideTrap) ||
                    (!hypWide && hypNarrowTrap));

  assign monTrap = monPresent && (curLevel != erw_pkg::LVL_MON) &&
                   ((monWide && monWideTrap &&
                     ((curLevel == erw_pkg::LVL_KERNEL) ||
                      (curLevel == erw_pkg::LVL_HYP))) ||
                    (!monWide && monNarrowTrap));

  // The live selector is used, so a selector write one cycle earlier
  // is already in effect here.
  assign inRange = (selector_r < erw_pkg::RECORD_COUNT);
  assign idx = selector_r[erw_pkg::IDX_W-1:0];

  assign doAccess = hit && !undef && !hypTrap && !monTrap;

  // Accepted accesses, split by target and direction
  assign selWrite = doAccess && !isView && reqWrite &&
                    (reqOpc2 == erw_pkg::OP2_SELECT);
  assign selRead = doAccess && !isView && !reqWrite;
  // Out-of-range views read zero and drop writes
  assign viewWrite = doAccess && isView && inRange && reqWrite;
  assign viewRead = doAccess && isView && inRange && !reqWrite;

  ////////////////////////////////////////////////////////////////////////
  // Selector

  // All 16 bits are kept so that an out-of-range value reads back as written
  always_comb begin
    selector_nxt = selector_r;
    if (selWrite) begin
      selector_nxt = reqWdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      selector_r <= erw_pkg::SEL_RESET;
    end else begin
      selector_r <= selector_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Records

  // A refused or out-of-range access leaves every record untouched
  always_comb begin
    addrRec_nxt = addrRec_r;
    ctlRec_nxt = ctlRec_r;
    if (viewWrite) begin
      case (reqOpc2)
        erw_pkg::OP2_ADDR_LO: begin
          addrRec_nxt[idx] = putHalf(addrRec_r[idx], 1'b0, reqWdata);
        end
        erw_pkg::OP2_ADDR_HI: begin
          addrRec_nxt[idx] = putHalf(addrRec_r[idx], 1'b1, reqWdata);
        end
        erw_pkg::OP2_CTL_LO: begin
          ctlRec_nxt[idx] = putHalf(ctlRec_r[idx], 1'b0, reqWdata);
        end
        erw_pkg::OP2_CTL_HI: begin
          ctlRec_nxt[idx] = putHalf(ctlRec_r[idx], 1'b1, reqWdata);
        end
        default: begin
          ctlRec_nxt = ctlRec_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < erw_pkg::RECORDS; i++) begin
        addrRec_r[i] <= erw_pkg::ADDR_RESET;
        ctlRec_r[i] <= erw_pkg::CTL_RESET;
      end
    end else begin
      addrRec_r <= addrRec_nxt;
      ctlRec_r <= ctlRec_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer flags

  // Priority is undefined, then hypervisor trap, then monitor trap
  always_comb begin
    respValid_nxt = hit;
    respUndef_nxt = hit && undef;
    respHypTrap_nxt = hit && !undef && hypTrap;
    respMonTrap_nxt = hit && !undef && !hypTrap && monTrap;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      respValid_r <= 1'b0;
      respUndef_r <= 1'b0;
      respHypTrap_r <= 1'b0;
      respMonTrap_r <= 1'b0;
    end else begin
      respValid_r <= respValid_nxt;
      respUndef_r <= respUndef_nxt;
      respHypTrap_r <= respHypTrap_nxt;
      respMonTrap_r <= respMonTrap_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  // Writes and refused accesses answer zero, never stale data
  always_comb begin
    respRdata_nxt = erw_pkg::DATA_ZERO;
    if (selRead) begin
      if (reqOpc2 == erw_pkg::OP2_SELECT) begin
        respRdata_nxt = {16'h0000, selector_r};
      end else begin
        respRdata_nxt = {16'h0000, erw_pkg::RECORD_COUNT};
      end
    end
    if (viewRead) begin
      case (reqOpc2)
        erw_pkg::OP2_ADDR_LO: begin
          respRdata_nxt = getHalf(addrRec_r[idx], 1'b0);
        end
        erw_pkg::OP2_ADDR_HI: begin
          respRdata_nxt = getHalf(addrRec_r[idx], 1'b1);
        end
        erw_pkg::OP2_CTL_LO: begin
          respRdata_nxt = getHalf(ctlRec_r[idx], 1'b0);
        end
        erw_pkg::OP2_CTL_HI: begin
          respRdata_nxt = getHalf(ctlRec_r[idx], 1'b1);
        end
        erw_pkg::OP2_FEAT_LO: begin
          respRdata_nxt = getHalf(erw_pkg::FEATURE_WORD, 1'b0);
        end
        default: begin
          respRdata_nxt = erw_pkg::DATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      respRdata_r <= erw_pkg::DATA_ZERO;
    end else begin
      respRdata_r <= respRdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign respValid = respValid_r;
  assign respRdata = respRdata_r;
  assign respUndef = respUndef_r;
  assign respHypTrap = respHypTrap_r;
  assign respMonTrap = respMonTrap_r;

endmodule : erw_record_window

// >>> erw_pkg.sv
/*
 * Constants for the selected error record window: coprocessor encodings,
 * privilege levels, record storage size and values after reset.
 * Assumes the core decodes coprocessor instructions and presents them one
 * at a time with the current privilege context alongside.
 */
// Functional notes
// - Word at c5/c4 opcode2 3 reads/writes fault address bits 31:0.
// - Word at c5/c4 opcode2 7 reads/writes fault address bits 63:32.
// - Word at c5/c4 opcode2 1 reads/writes control word bits 31:0.
// - Word at c5/c4 opcode2 5 reads/writes control word bits 63:32.
// - Word at c5/c4 opcode2 0 is read-only feature word bits 31:0.
// - Any access from the user level is undefined.
// - Out-of-range selector or no records: views read zero, drop writes.
// - Wide hyp trap bit: non-secure kernel access traps to hypervisor.
// - Narrow hyp trap bit: non-secure kernel access raises hyp trap.
// - Wide monitor trap bit: kernel and hyp accesses trap to monitor.
// - Narrow monitor trap bit: all but monitor mode raise monitor trap.
// - One copy of each view serves both security states.
// - Without the reliability extension every access is undefined.
// - A 16-bit selector register picks the record all views reach.
// - Read-only 16-bit count gives highest record index plus one.
package erw_pkg;

  // Coprocessor encoding shared by all views
  localparam logic [3:0] CP_NUM = 4'hF;
  localparam logic [2:0] CP_OPC1 = 3'h0;
  localparam logic [3:0] CP_CRN = 4'h5;
  localparam logic [3:0] CRM_IDENT = 4'h3;
  localparam logic [3:0] CRM_VIEW = 4'h4;

  // opcode2 under CRM_IDENT
  localparam logic [2:0] OP2_COUNT = 3'h0;
  localparam logic [2:0] OP2_SELECT = 3'h1;

  // opcode2 under CRM_VIEW
  localparam logic [2:0] OP2_FEAT_LO = 3'h0;
  localparam logic [2:0] OP2_CTL_LO = 3'h1;
  localparam logic [2:0] OP2_ADDR_LO = 3'h3;
  localparam logic [2:0] OP2_CTL_HI = 3'h5;
  localparam logic [2:0] OP2_ADDR_HI = 3'h7;

  // Privilege levels on curLevel
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_KERNEL = 2'h1;
  localparam logic [1:0] LVL_HYP = 2'h2;
  localparam logic [1:0] LVL_MON = 2'h3;

  // Record storage
  localparam int RECORDS = 4;
  localparam int IDX_W = 2;
  localparam logic [15:0] RECORD_COUNT = 16'h0004;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [63:0] ADDR_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CTL_RESET = 64'h0000_0000_0000_0000;
  // Feature word value is arbitrary; every record reports the same one
  localparam logic [63:0] FEATURE_WORD = 64'h0000_0000_0000_00A5;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : erw_pkg

// >>> erw_checker.sv
/* Assertions on the ports of erw_record_window.
   Bound to the design; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module erw_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [3:0] reqCoproc,
  input wire logic [2:0] reqOpc1,
  input wire logic [3:0] reqCrn,
  input wire logic [3:0] reqCrm,
  input wire logic [2:0] reqOpc2,
  input wire logic [1:0] curLevel,
  input wire logic curSecure,
  input wire logic rasPresent,
  input wire logic hypPresent,
  input wire logic hypWide,
  input wire logic hypWideTrap,
  input wire logic hypNarrowTrap,
  input wire logic monPresent,
  input wire logic monWide,
  input wire logic monWideTrap,
  input wire logic monNarrowTrap,
  input wire logic respValid,
  input wire logic [31:0] respRdata,
  input wire logic respUndef,
  input wire logic respHypTrap,
  input wire logic respMonTrap
);
  logic hit, go, hyp, mon;
  assign hit = reqValid && reqCoproc == 4'hF && reqOpc1 == 3'h0
    && reqCrn == 4'h5 && (reqCrm == 4'h3 && reqOpc2 < 3'h2
    || reqCrm == 4'h4 && (reqOpc2[0] || reqOpc2 == 3'h0));
  assign go = hit && rasPresent && curLevel != 2'h0
    && !(reqWrite && reqOpc2 == 3'h0);
  assign hyp = hypPresent && curLevel == 2'h1 && !curSecure
    && (hypWide ? hypWideTrap : hypNarrowTrap);
  assign mon = monPresent && curLevel != 2'h3
    && (monWide ? monWideTrap : monNarrowTrap);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence sClean;
    respValid && !respUndef && !respHypTrap && !respMonTrap;
  endsequence
  sequence sRefused;
    respValid && respRdata == 32'h0;
  endsequence
  a_answer_next:
    assert property (hit |=> respValid) else $error("answer missing");
  a_no_stray:
    assert property (!hit |=> !respValid) else $error("stray answer");
  a_undef_cause:
    assert property (hit && !go |=> respUndef) else $error("undef missing");
  a_hyp_route:
    assert property (go && hyp |=> respHypTrap) else $error("no hyp trap");
  a_mon_route:
    assert property (go && !hyp && mon |=> respMonTrap)
      else $error("no monitor trap");
  a_clean_pass:
    assert property (go && !hyp && !mon |=> sClean)
      else $error("access refused wrongly");
  a_refuse_zero:
    assert property (respUndef || respHypTrap || respMonTrap |-> sRefused)
      else $error("refused answer not zero");
  a_write_zero:
    assert property (hit && reqWrite |=> respRdata == 32'h0)
      else $error("write returned data");
  a_count_value:
    assert property (go && !hyp && !mon && reqCrm == 4'h3
      && reqOpc2 == 3'h0 |=> respRdata == {16'h0, erw_pkg::RECORD_COUNT})
      else $error("record count wrong");
endmodule : erw_checker

bind erw_record_window erw_checker chk (.clk, .nrst, .reqValid, .reqWrite,
  .reqCoproc, .reqOpc1, .reqCrn, .reqCrm, .reqOpc2, .curLevel, .curSecure,
  .rasPresent, .hypPresent, .hypWide, .hypWideTrap, .hypNarrowTrap,
  .monPresent, .monWide, .monWideTrap, .monNarrowTrap, .respValid,
  .respRdata, .respUndef, .respHypTrap, .respMonTrap);

// >>> tb_erw_record_window.sv
/* Self-checking bench for erw_record_window.
   Drives at falling edges; a reference model predicts every answer. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmpCount++; if ((e) !== (g)) begin nErrors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_erw_record_window;
  logic clk = 1'h0, nrst = 1'h0, reqValid = 1'h0, reqWrite = 1'h0;
  logic [3:0] reqCoproc = 4'hF, reqCrn = 4'h5, reqCrm = 4'h4;
  logic [2:0] reqOpc1 = 3'h0, reqOpc2 = 3'h0;
  logic [31:0] reqWdata = 32'h0, respRdata;
  logic [1:0] curLevel = 2'h1;
  logic curSecure = 1'h0, rasPresent = 1'h1, hypPresent = 1'h1;
  logic hypWide = 1'h1, hypWideTrap = 1'h0, hypNarrowTrap = 1'h0;
  logic monPresent = 1'h1, monWide = 1'h1, monWideTrap = 1'h0;
  logic monNarrowTrap = 1'h0, respValid, respUndef, respHypTrap, respMonTrap;
  logic [63:0] mAddr [4], mCtl [4], w64;
  logic [15:0] mSel;
  logic [35:0] expR;
  int nErrors = 0, cmpCount = 0, cycles = 0;
  always #2.5 clk = ~clk;
  erw_record_window dut (.clk, .nrst, .reqValid, .reqWrite, .reqCoproc,
    .reqOpc1, .reqCrn, .reqCrm, .reqOpc2, .reqWdata, .curLevel, .curSecure,
    .rasPresent, .hypPresent, .hypWide, .hypWideTrap, .hypNarrowTrap,
    .monPresent, .monWide, .monWideTrap, .monNarrowTrap, .respValid,
    .respRdata, .respUndef, .respHypTrap, .respMonTrap);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] predict();
    logic [31:0] rd;
    rd = 32'h0;
    if (!(reqCoproc == 4'hF && reqOpc1 == 3'h0 && reqCrn == 4'h5 &&
        (reqCrm == 4'h3 && reqOpc2 < 3'h2 ||
        reqCrm == 4'h4 && (reqOpc2[0] || reqOpc2 == 3'h0))))
      return 36'h0;
    if (!rasPresent || curLevel == 2'h0 || reqWrite && reqOpc2 == 3'h0)
      return {4'hC, rd};
    if (hypPresent && curLevel == 2'h1 && !curSecure &&
        (hypWide ? hypWideTrap : hypNarrowTrap))
      return {4'hA, rd};
    if (monPresent && curLevel != 2'h3 &&
        (monWide ? monWideTrap : monNarrowTrap))
      return {4'h9, rd};
    if (reqCrm == 4'h3) begin
      if (reqOpc2 == 3'h0)
        rd = {16'h0, erw_pkg::RECORD_COUNT};
      else if (reqWrite)
        mSel = reqWdata[15:0];
      else
        rd = {16'h0, mSel};
    end else if (reqOpc2 == 3'h0 && mSel < erw_pkg::RECORD_COUNT) begin
      rd = erw_pkg::FEATURE_WORD[31:0];
    end else if (mSel < erw_pkg::RECORD_COUNT) begin
      // Opcode2 bit 1 picks the address word, bit 2 the upper half
      w64 = reqOpc2[1] ? mAddr[mSel[1:0]] : mCtl[mSel[1:0]];
      rd = reqOpc2[2] ? w64[63:32] : w64[31:0];
      if (reqWrite && reqOpc2[2])
        w64[63:32] = reqWdata;
      else if (reqWrite)
        w64[31:0] = reqWdata;
      if (reqWrite && reqOpc2[1])
        mAddr[mSel[1:0]] = w64;
      else if (reqWrite)
        mCtl[mSel[1:0]] = w64;
      if (reqWrite)
        rd = 32'h0;
    end
    return {4'h8, rd};
  endfunction : predict
  task automatic acc(input logic w, input logic [3:0] crm,
      input logic [2:0] o2, input logic [31:0] wd);
    logic [35:0] seen;
    reqValid = 1'h1;
    reqWrite = w;
    reqCrm = crm;
    reqOpc2 = o2;
    reqWdata = wd;
    expR = predict();
    @(negedge clk);
    seen = {respValid, respUndef, respHypTrap, respMonTrap, respRdata};
    `CHK("response", expR, seen)
  endtask : acc
  task automatic ctx(input logic rnd);
    {curLevel, curSecure, hypWide, monWide} = rnd ? 5'($urandom) : 5'h08;
    {hypWideTrap, hypNarrowTrap, monWideTrap, monNarrowTrap} =
      rnd ? 4'($urandom & $urandom) : 4'h0;
    {hypPresent, monPresent} = rnd ? 2'($urandom) : 2'h3;
    rasPresent = !rnd || $urandom % 8 != 0;
  endtask : ctx
  task automatic rst_model();
    mSel = erw_pkg::SEL_RESET;
    for (int r = 0; r < 4; r++) begin
      mAddr[r] = erw_pkg::ADDR_RESET;
      mCtl[r] = erw_pkg::CTL_RESET;
    end
  endtask : rst_model
  task stop_test();
    $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      nErrors++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int s;
    s = $urandom(32'h6CDC);
    rst_model();
    repeat (6) @(negedge clk);
    nrst = 1'h1;
    for (int r = 0; r < 4; r++) begin
      acc(1'h1, 4'h3, 3'h1, 32'(r));
      for (int k = 0; k < 8; k++)
        if (k % 2 == 1 || k == 0)
          acc(1'h0, 4'h4, 3'(k), 32'h0);
    end
    $display("test reset values done");
    for (int k = 0; k < 64; k++) begin
      {curLevel, curSecure, hypWide, monWide} = 5'(k);
      {hypWideTrap, hypNarrowTrap, monWideTrap, monNarrowTrap} = {4{k >= 32}};
      acc(1'h0, 4'h4, 3'h3, 32'h0);
    end
    ctx(1'h0);
    acc(1'h1, 4'h4, 3'h0, 32'h5A);
    acc(1'h1, 4'h3, 3'h0, 32'h7);
    acc(1'h0, 4'h3, 3'h0, 32'h0);
    rasPresent = 1'h0;
    acc(1'h0, 4'h4, 3'h3, 32'h0);
    rasPresent = 1'h1;
    $display("test access rights done");
    acc(1'h1, 4'h3, 3'h1, 32'h4);
    acc(1'h1, 4'h4, 3'h3, 32'h1234_5678);
    acc(1'h0, 4'h4, 3'h3, 32'h0);
    acc(1'h1, 4'h3, 3'h1, 32'hFFFF);
    acc(1'h0, 4'h3, 3'h1, 32'h0);
    acc(1'h1, 4'h3, 3'h1, 32'h0);
    acc(1'h0, 4'h4, 3'h3, 32'h0);
    $display("test selector range done");
    repeat (600) begin
      ctx(1'h1);
      reqCoproc = $urandom % 16 == 0 ? 4'h0 : 4'hF;
      reqCrn = $urandom % 16 == 0 ? 4'h6 : 4'h5;
      reqOpc1 = $urandom % 16 == 0 ? 3'h2 : 3'h0;
      acc(1'($urandom), $urandom % 2 ? 4'h3 : 4'h4, 3'($urandom),
        $urandom % 3 == 0 ? $urandom : $urandom % 6);
    end
    {reqCoproc, reqCrn} = 8'hF5;
    reqOpc1 = 3'h0;
    $display("test random traffic done");
    reqValid = 1'h0;
    nrst = 1'h0;
    repeat (2) @(negedge clk);
    nrst = 1'h1;
    rst_model();
    ctx(1'h0);
    acc(1'h0, 4'h4, 3'h7, 32'h0);
    acc(1'h0, 4'h3, 3'h1, 32'h0);
    reqValid = 1'h0;
    $display("test second reset done");
    stop_test();
  end
endmodule : tb_erw_record_window
